//--- chp_pkg.sv
package chp_pkg;

   localparam int ADDR_W = 11;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int IDE_ADDR_W = 3;
   localparam int SYNC_STAGES = 2;

   // Control pin vector, one bit per pin, after the synchroniser
   localparam int CTL_W = 8;
   localparam int CTL_LOW_SEL = 0;
   localparam int CTL_HIGH_SEL = 1;
   localparam int CTL_IO_READ_STROBE_N = 2;
   localparam int CTL_IDE_SEL = 3;
   localparam int CTL_DRV_SEL = 4;
   localparam int CTL_ATTR_SEL = 5;
   localparam int CTL_DIAG_PIN = 6;
   localparam int CTL_ACT_PIN = 7;

   // Idle level of every low-active pin, also the synchroniser reset value
   localparam logic [CTL_W-1:0] CTL_IDLE = 8'hFF;
   localparam logic [ADDR_W-1:0] ADDR_IDLE = 11'h000;

   // Cycles after reset release before the straps are trusted
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   localparam logic CARD_DETECT_LEVEL = 1'h0;
   localparam logic BATTERY_OK_LEVEL = 1'h1;
   localparam logic SPEAKER_IDLE_LEVEL = 1'h1;
   localparam logic [DATA_W-1:0] DATA_IDLE = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

   typedef enum logic [2:0]
   {
      CHP_MODE_MEM = 3'h1,
      CHP_MODE_IO = 3'h2,
      CHP_MODE_IDE = 3'h4
   } chp_mode_t;

   typedef enum logic [3:0]
   {
      CHP_RD_IDLE = 4'h1,
      CHP_RD_REQ = 4'h2,
      CHP_RD_LATCH = 4'h4,
      CHP_RD_DRIVE = 4'h8
   } chp_rd_t;

   typedef enum logic [2:0]
   {
      CHP_XFER_NONE = 3'h0,
      CHP_XFER_WORD = 3'h1,
      CHP_XFER_EVEN_LOW = 3'h2,
      CHP_XFER_ODD_LOW = 3'h3,
      CHP_XFER_ODD_HIGH = 3'h4
   } chp_xfer_t;

endpackage : chp_pkg

//--- chp_pin_sync.sv
`timescale 1ns/100ps
module chp_pin_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] IDLE = '0
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinSync
);

   logic [WIDTH-1:0] stageOne_ff;
   logic [WIDTH-1:0] stageTwo_ff;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         stageOne_ff <= IDLE;
         stageTwo_ff <= IDLE;
      end
      else
      begin
         stageOne_ff <= pinIn;
         stageTwo_ff <= stageOne_ff;
      end
   end

   assign pinSync = stageTwo_ff;

endmodule : chp_pin_sync

//--- chp_access_decode.sv
`timescale 1ns/100ps
module chp_access_decode (
   input wire chp_pkg::chp_mode_t mode,
   input wire logic [chp_pkg::ADDR_W-1:0] addr,
   input wire logic lowSelN,
   input wire logic highSelN,
   input wire logic attrSelN,
   output logic [chp_pkg::ADDR_W-1:0] effAddr,
   output chp_pkg::chp_xfer_t xfer,
   output logic altBank,
   output logic attrSpace,
   output logic selected
);

   always_comb
   begin
      effAddr = addr; // R1
      xfer = chp_pkg::CHP_XFER_NONE;
      altBank = 1'b0;
      attrSpace = 1'b0;
      selected = !lowSelN || !highSelN; // R8
      if (mode == chp_pkg::CHP_MODE_IDE)
      begin
         // Upper lines are grounded by the host, masked anyway
         effAddr = {{(chp_pkg::ADDR_W-chp_pkg::IDE_ADDR_W){1'b0}},
                    addr[chp_pkg::IDE_ADDR_W-1:0]}; // R2
         altBank = !highSelN; // R10 R11
         xfer = selected ? chp_pkg::CHP_XFER_WORD : chp_pkg::CHP_XFER_NONE;
      end
      else
      begin
         attrSpace = (mode == chp_pkg::CHP_MODE_MEM) && !attrSelN; // R22
         case ({highSelN, lowSelN}) // R9
            2'b00: xfer = chp_pkg::CHP_XFER_WORD;
            2'b10: xfer = addr[0] ? chp_pkg::CHP_XFER_ODD_LOW : chp_pkg::CHP_XFER_EVEN_LOW;
            2'b01: xfer = chp_pkg::CHP_XFER_ODD_HIGH;
            default: xfer = chp_pkg::CHP_XFER_NONE;
         endcase
      end
   end

endmodule : chp_access_decode

//--- card_host_pin_interface.sv
`timescale 1ns/100ps
// Contract
// R1: Memory and I/O modes decode all eleven address lines, top line is MSB.
// R2: True IDE decodes only three low address lines; host grounds the rest.
// R3: Memory mode drives both battery status pins high permanently.
// R4: I/O mode drives the speaker pin high permanently.
// R5: I/O mode signals configuration/status register changes on status-change pin.
// R6: True IDE uses two shared pins for master/slave diagnostic handshake.
// R7: Both card-detect outputs are tied low in every mode.
// R8: Host selects the card by driving either byte select low.
// R9: Memory mode picks byte, word or odd-byte from selects and lowest address.
// R10: True IDE high-byte select reaches alternate status and device control.
// R11: True IDE low-byte select reaches the other task-file registers.
// R12: True IDE is master with drive select grounded, slave when open.
// R13: Memory mode ignores drive select and the I/O read strobe.
// R14: Sixteen-bit data bus; line 0 even byte LSB, line 8 odd byte LSB.
// R15: Input acknowledge is unused outside I/O mode; host leaves it open.
// R16: I/O mode drives input acknowledge low while selected and read strobe low.
// R17: Host steers its input data buffer with input acknowledge.
// R18: I/O and True IDE modes return task-file data on the read strobe.
// R19: I/O mode ignores the read strobe until the interface is configured.
// R20: True IDE ignores the read strobe until the interface is set up.
// R21: Host grounds the IDE mode select to choose True IDE.
// R22: Memory mode attribute select high means task file, low attribute memory.
// R23: Operating mode taken from the strap at reset and held until next reset; code holds only the IDE strap, memory or I/O follows cfgIoMode live.
// R24: Data bus stays released whenever no read strobe is being served.
module card_host_pin_interface (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [chp_pkg::ADDR_W-1:0] addrPin,
   input wire logic low_byte_select_n,
   input wire logic high_byte_select_n,
   input wire logic io_read_strobe_n,
   input wire logic ide_mode_select_n,
   input wire logic drive_select_n,
   input wire logic attribute_select_n,
   input wire logic [chp_pkg::DATA_W-1:0] dataPinIn,
   output logic [chp_pkg::DATA_W-1:0] dataPinOut,
   output logic [1:0] dataPinOe,
   input wire logic diagPinIn,
   output logic diagPinOut,
   output logic diagPinOe,
   input wire logic activityPinIn,
   output logic activityPinOut,
   output logic activityPinOe,
   output logic card_detect_one_n,
   output logic card_detect_two_n,
   output logic input_ack_n,
   input wire logic cfgIoMode,
   input wire logic interfaceReady,
   input wire logic cfgStatusChanged,
   input wire logic diagDone,
   input wire logic diagPassed,
   input wire logic driveActive,
   input wire logic [chp_pkg::DATA_W-1:0] tfReadData,
   output logic tfReadReq,
   output logic [chp_pkg::ADDR_W-1:0] tfAddr,
   output logic tfAltBank,
   output logic [chp_pkg::DATA_W-1:0] hostWriteData,
   output chp_pkg::chp_mode_t cardMode,
   output logic modeValid,
   output logic deviceIsSlave,
   output logic slavePresent,
   output logic slaveDiagPassed,
   output logic memSelected,
   output chp_pkg::chp_xfer_t memXfer,
   output logic memAttrAccess
);

   logic [chp_pkg::ADDR_W-1:0] addrSync;
   logic [chp_pkg::CTL_W-1:0] ctlSync;
   logic [chp_pkg::DATA_W-1:0] dataSync;
   logic [chp_pkg::ADDR_W-1:0] decAddr;
   chp_pkg::chp_xfer_t decXfer;
   logic decAltBank;
   logic decAttr;
   logic decSelected;
   logic readStrobe;
   logic respond;

   logic [1:0] settleCnt_ff;
   logic modeValid_ff;
   logic ideStrap_ff;
   logic slaveStrap_ff;
   chp_pkg::chp_mode_t mode_ff;
   chp_pkg::chp_mode_t nxt_mode;
   chp_pkg::chp_rd_t rdState_ff;
   chp_pkg::chp_rd_t nxt_rdState;
   chp_pkg::chp_xfer_t rdXfer_ff;
   logic tfReadReq_ff;
   logic [chp_pkg::ADDR_W-1:0] tfAddr_ff;
   logic tfAltBank_ff;
   logic [chp_pkg::DATA_W-1:0] dataOut_ff;
   logic [1:0] dataOe_ff;
   logic inputAck_n_ff;
   logic diagOut_ff;
   logic diagOe_ff;
   logic actOut_ff;
   logic actOe_ff;
   logic cardDetectOne_n_ff;
   logic cardDetectTwo_n_ff;
   logic slavePresent_ff;
   logic slaveDiagPassed_ff;
   logic memSelected_ff;
   chp_pkg::chp_xfer_t memXfer_ff;
   logic memAttr_ff;
   logic [chp_pkg::DATA_W-1:0] hostData_ff;

   chp_pin_sync #(
      .WIDTH(chp_pkg::ADDR_W),
      .IDLE(chp_pkg::ADDR_IDLE)
   ) addrSyncInst (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pinIn(addrPin),
      .pinSync(addrSync)
   );

   chp_pin_sync #(
      .WIDTH(chp_pkg::CTL_W),
      .IDLE(chp_pkg::CTL_IDLE)
   ) ctlSyncInst (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pinIn({activityPinIn, diagPinIn, attribute_select_n, drive_select_n,
              ide_mode_select_n, io_read_strobe_n, high_byte_select_n,
              low_byte_select_n}),
      .pinSync(ctlSync)
   );

   chp_pin_sync #(
      .WIDTH(chp_pkg::DATA_W),
      .IDLE(chp_pkg::DATA_IDLE)
   ) dataSyncInst (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pinIn(dataPinIn),
      .pinSync(dataSync)
   );

   chp_access_decode decodeInst (
      .mode(mode_ff),
      .addr(addrSync),
      .lowSelN(ctlSync[chp_pkg::CTL_LOW_SEL]),
      .highSelN(ctlSync[chp_pkg::CTL_HIGH_SEL]),
      .attrSelN(ctlSync[chp_pkg::CTL_ATTR_SEL]),
      .effAddr(decAddr),
      .xfer(decXfer),
      .altBank(decAltBank),
      .attrSpace(decAttr),
      .selected(decSelected)
   );

   // Straps are read only after the synchronisers have refilled past reset
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         settleCnt_ff <= 2'h0;
         modeValid_ff <= 1'b0;
         ideStrap_ff <= 1'b0;
         slaveStrap_ff <= 1'b0;
      end
      else if (!modeValid_ff)
      begin
         if (settleCnt_ff == chp_pkg::STRAP_SETTLE)
         begin
            modeValid_ff <= 1'b1;
            ideStrap_ff <= !ctlSync[chp_pkg::CTL_IDE_SEL]; // R23 R21
            slaveStrap_ff <= !ctlSync[chp_pkg::CTL_IDE_SEL]
                             && ctlSync[chp_pkg::CTL_DRV_SEL]; // R12
         end
         else
         begin
            settleCnt_ff <= settleCnt_ff + 2'h1;
         end
      end
   end

   always_comb
   begin
      if (ideStrap_ff)
      begin
         nxt_mode = chp_pkg::CHP_MODE_IDE; // R23
      end
      else if (cfgIoMode)
      begin
         nxt_mode = chp_pkg::CHP_MODE_IO;
      end
      else
      begin
         nxt_mode = chp_pkg::CHP_MODE_MEM;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         mode_ff <= chp_pkg::CHP_MODE_MEM;
      end
      else if (modeValid_ff)
      begin
         mode_ff <= nxt_mode;
      end
   end

   // Memory mode never answers the I/O strobe; the others wait for setup
   assign readStrobe = !ctlSync[chp_pkg::CTL_IO_READ_STROBE_N];
   assign respond = modeValid_ff && (mode_ff != chp_pkg::CHP_MODE_MEM) // R13
                    && interfaceReady && decSelected && readStrobe; // R19 R20

   always_comb
   begin
      case (rdState_ff)
         chp_pkg::CHP_RD_IDLE:
            nxt_rdState = respond ? chp_pkg::CHP_RD_REQ : chp_pkg::CHP_RD_IDLE; // R18
         chp_pkg::CHP_RD_REQ:
            nxt_rdState = chp_pkg::CHP_RD_LATCH;
         chp_pkg::CHP_RD_LATCH:
            nxt_rdState = chp_pkg::CHP_RD_DRIVE;
         chp_pkg::CHP_RD_DRIVE:
            nxt_rdState = respond ? chp_pkg::CHP_RD_DRIVE : chp_pkg::CHP_RD_IDLE;
         default:
            nxt_rdState = chp_pkg::CHP_RD_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rdState_ff <= chp_pkg::CHP_RD_IDLE;
      end
      else
      begin
         rdState_ff <= nxt_rdState;
      end
   end

   // Address and bank are frozen for the whole read
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         tfReadReq_ff <= 1'b0;
         tfAddr_ff <= chp_pkg::ADDR_IDLE;
         tfAltBank_ff <= 1'b0;
         rdXfer_ff <= chp_pkg::CHP_XFER_NONE;
      end
      else
      begin
         tfReadReq_ff <= (nxt_rdState == chp_pkg::CHP_RD_REQ); // R18
         if (nxt_rdState == chp_pkg::CHP_RD_REQ)
         begin
            tfAddr_ff <= decAddr; // R1 R2
            tfAltBank_ff <= decAltBank; // R10 R11
            rdXfer_ff <= decXfer; // R9
         end
      end
   end

   // Byte steering: even byte on lines 7..0, odd byte on 15..8 unless moved down
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         dataOut_ff <= chp_pkg::DATA_IDLE;
         dataOe_ff <= 2'h0;
      end
      else if (rdState_ff == chp_pkg::CHP_RD_LATCH)
      begin
         case (rdXfer_ff) // R14
            chp_pkg::CHP_XFER_WORD:
            begin
               dataOut_ff <= tfReadData;
               dataOe_ff <= 2'h3;
            end
            chp_pkg::CHP_XFER_EVEN_LOW:
            begin
               dataOut_ff <= {chp_pkg::BYTE_ZERO, tfReadData[chp_pkg::BYTE_W-1:0]};
               dataOe_ff <= 2'h1;
            end
            chp_pkg::CHP_XFER_ODD_LOW:
            begin
               dataOut_ff <= {chp_pkg::BYTE_ZERO,
                              tfReadData[chp_pkg::DATA_W-1:chp_pkg::BYTE_W]};
               dataOe_ff <= 2'h1;
            end
            chp_pkg::CHP_XFER_ODD_HIGH:
            begin
               dataOut_ff <= {tfReadData[chp_pkg::DATA_W-1:chp_pkg::BYTE_W],
                              chp_pkg::BYTE_ZERO};
               dataOe_ff <= 2'h2;
            end
            default:
            begin
               dataOut_ff <= chp_pkg::DATA_IDLE;
               dataOe_ff <= 2'h0;
            end
         endcase
      end
      else if (nxt_rdState != chp_pkg::CHP_RD_DRIVE)
      begin
         dataOe_ff <= 2'h0; // R24
      end
   end

   // Follows the strobe, not the data, so the host buffer turns early
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         inputAck_n_ff <= 1'b1;
      end
      else
      begin
         inputAck_n_ff <= !((mode_ff == chp_pkg::CHP_MODE_IO) && respond); // R16 R15
      end
   end

   // Shared pins: battery status, status change and speaker, or the handshake
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !modeValid_ff)
      begin
         diagOut_ff <= 1'b1;
         diagOe_ff <= 1'b0;
         actOut_ff <= 1'b1;
         actOe_ff <= 1'b0;
      end
      else
      begin
         case (mode_ff)
            chp_pkg::CHP_MODE_MEM:
            begin
               diagOut_ff <= chp_pkg::BATTERY_OK_LEVEL; // R3
               diagOe_ff <= 1'b1;
               actOut_ff <= chp_pkg::BATTERY_OK_LEVEL; // R3
               actOe_ff <= 1'b1;
            end
            chp_pkg::CHP_MODE_IO:
            begin
               diagOut_ff <= !cfgStatusChanged; // R5
               diagOe_ff <= 1'b1;
               actOut_ff <= chp_pkg::SPEAKER_IDLE_LEVEL; // R4
               actOe_ff <= 1'b1;
            end
            chp_pkg::CHP_MODE_IDE:
            begin
               // Open-drain style: only ever pulled low, released otherwise
               diagOut_ff <= 1'b0;
               diagOe_ff <= slaveStrap_ff && diagDone && diagPassed; // R6
               actOut_ff <= 1'b0;
               actOe_ff <= driveActive || (slaveStrap_ff && !diagDone); // R6
            end
            default:
            begin
               diagOut_ff <= 1'b1;
               diagOe_ff <= 1'b0;
               actOut_ff <= 1'b1;
               actOe_ff <= 1'b0;
            end
         endcase
      end
   end

   // Master watches the slave's handshake pins
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         slavePresent_ff <= 1'b0;
         slaveDiagPassed_ff <= 1'b0;
      end
      else
      begin
         slavePresent_ff <= (mode_ff == chp_pkg::CHP_MODE_IDE) && !slaveStrap_ff
                            && !ctlSync[chp_pkg::CTL_ACT_PIN] && !actOe_ff; // R6
         slaveDiagPassed_ff <= (mode_ff == chp_pkg::CHP_MODE_IDE) && !slaveStrap_ff
                               && !ctlSync[chp_pkg::CTL_DIAG_PIN]; // R6
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cardDetectOne_n_ff <= chp_pkg::CARD_DETECT_LEVEL;
         cardDetectTwo_n_ff <= chp_pkg::CARD_DETECT_LEVEL;
      end
      else
      begin
         cardDetectOne_n_ff <= chp_pkg::CARD_DETECT_LEVEL; // R7
         cardDetectTwo_n_ff <= chp_pkg::CARD_DETECT_LEVEL; // R7
      end
   end

   // Memory-cycle decode for the strobe logic kept outside this block
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         memSelected_ff <= 1'b0;
         memXfer_ff <= chp_pkg::CHP_XFER_NONE;
         memAttr_ff <= 1'b0;
      end
      else
      begin
         memSelected_ff <= modeValid_ff && decSelected; // R8
         memXfer_ff <= decXfer; // R9
         memAttr_ff <= decAttr; // R22
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         hostData_ff <= chp_pkg::DATA_IDLE;
      end
      else
      begin
         hostData_ff <= dataSync; // R14
      end
   end

   assign dataPinOut = dataOut_ff;
   assign dataPinOe = dataOe_ff;
   assign diagPinOut = diagOut_ff;
   assign diagPinOe = diagOe_ff;
   assign activityPinOut = actOut_ff;
   assign activityPinOe = actOe_ff;
   assign card_detect_one_n = cardDetectOne_n_ff;
   assign card_detect_two_n = cardDetectTwo_n_ff;
   assign input_ack_n = inputAck_n_ff;
   assign tfReadReq = tfReadReq_ff;
   assign tfAddr = tfAddr_ff;
   assign tfAltBank = tfAltBank_ff;
   assign hostWriteData = hostData_ff;
   assign cardMode = mode_ff;
   assign modeValid = modeValid_ff;
   assign deviceIsSlave = slaveStrap_ff;
   assign slavePresent = slavePresent_ff;
   assign slaveDiagPassed = slaveDiagPassed_ff;
   assign memSelected = memSelected_ff;
   assign memXfer = memXfer_ff;
   assign memAttrAccess = memAttr_ff;

endmodule : card_host_pin_interface

//--- chp_host_pin_asserts.sv
`timescale 1ns/100ps
module chp_host_pin_asserts (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic low_byte_select_n,
   input wire logic io_read_strobe_n,
   input wire logic [1:0] dataPinOe,
   input wire logic diagPinOut,
   input wire logic diagPinOe,
   input wire logic activityPinOut,
   input wire logic activityPinOe,
   input wire logic card_detect_one_n,
   input wire logic card_detect_two_n,
   input wire logic input_ack_n,
   input wire logic interfaceReady,
   input wire logic cfgStatusChanged,
   input wire logic tfReadReq,
   input wire logic [chp_pkg::ADDR_W-1:0] tfAddr,
   input wire chp_pkg::chp_mode_t cardMode,
   input wire logic modeValid
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence ioReadHeld;
      cardMode == chp_pkg::CHP_MODE_IO && modeValid && interfaceReady && !low_byte_select_n
         && !io_read_strobe_n;
   endsequence
   sequence strobeIdle;
      io_read_strobe_n [*5];
   endsequence

   card_detect_a: assert property (!card_detect_one_n && !card_detect_two_n)
      else $error("card detect pin not low");
   mem_battery_a: assert property (cardMode == chp_pkg::CHP_MODE_MEM && $past(modeValid)
      && $past(cardMode) == chp_pkg::CHP_MODE_MEM |-> diagPinOut && diagPinOe
      && activityPinOut && activityPinOe) else $error("battery pins not driven high");
   io_pins_a: assert property (cardMode == chp_pkg::CHP_MODE_IO
      && $past(cardMode) == chp_pkg::CHP_MODE_IO |-> activityPinOut && activityPinOe
      && diagPinOe && diagPinOut == !$past(cfgStatusChanged))
      else $error("speaker or status change pin wrong");
   io_ack_a: assert property (ioReadHeld [*5] |-> !input_ack_n)
      else $error("input acknowledge missing");
   bus_release_a: assert property (strobeIdle |-> dataPinOe == 2'b00 && input_ack_n)
      else $error("data bus driven without read");
   mem_quiet_a: assert property (cardMode == chp_pkg::CHP_MODE_MEM [*3]
      |-> !tfReadReq && input_ack_n) else $error("memory mode answered read strobe");
   not_ready_a: assert property (!interfaceReady [*3] |-> !tfReadReq)
      else $error("read taken before setup");
   mode_hold_a: assert property (modeValid && $past(modeValid, 2) |-> $stable(cardMode))
      else $error("mode changed without reset");
   ide_addr_a: assert property (cardMode == chp_pkg::CHP_MODE_IDE && tfReadReq
      |-> tfAddr[10:3] == 8'h00) else $error("upper address decoded in ide mode");
endmodule : chp_host_pin_asserts

bind card_host_pin_interface chp_host_pin_asserts i_chp_host_pin_asserts (.sys_clk, .sys_rst,
   .low_byte_select_n, .io_read_strobe_n, .dataPinOe, .diagPinOut, .diagPinOe, .activityPinOut,
   .activityPinOe, .card_detect_one_n, .card_detect_two_n, .input_ack_n, .interfaceReady,
   .cfgStatusChanged, .tfReadReq, .tfAddr, .cardMode, .modeValid);

//--- chp_tf_model.sv
`timescale 1ns/100ps
module chp_tf_model (
   input wire logic sys_clk,
   input wire logic tfReadReq,
   input wire logic [chp_pkg::ADDR_W-1:0] tfAddr,
   output logic [chp_pkg::DATA_W-1:0] tfReadData
);
   logic [chp_pkg::DATA_W-1:0] readData_ff;

   // Valid only the cycle after a request; churns otherwise so stale data is caught
   always_ff @(posedge sys_clk)
   begin
      if (tfReadReq)
      begin
         readData_ff <= {tfAddr, 5'h16};
      end
      else
      begin
         readData_ff <= ~readData_ff;
      end
   end
   assign tfReadData = readData_ff;
endmodule : chp_tf_model

//--- card_host_pin_interface_tb.sv
`timescale 1ns/100ps
module card_host_pin_interface_tb;
   logic sys_clk = 1'b0, sys_rst = 1'b1;
   logic [10:0] addrPin = 11'h000;
   logic low_byte_select_n = 1'b1, high_byte_select_n = 1'b1, io_read_strobe_n = 1'b1;
   logic ide_mode_select_n = 1'b1, drive_select_n = 1'b0, attribute_select_n = 1'b1;
   logic cfgIoMode = 1'b0, interfaceReady = 1'b0, cfgStatusChanged = 1'b0;
   logic diagDone = 1'b0, diagPassed = 1'b0, driveActive = 1'b0, actHost = 1'b1;
   logic [15:0] hostData = 16'h5AC3, dataPinIn, dataPinOut, tfReadData, hostWriteData, rdData;
   logic [1:0] dataPinOe, rdOe;
   logic diagPinIn, diagPinOut, diagPinOe, activityPinIn, activityPinOut, activityPinOe;
   logic card_detect_one_n, card_detect_two_n, input_ack_n, tfReadReq, tfAltBank, modeValid;
   logic deviceIsSlave, slavePresent, slaveDiagPassed, memSelected, memAttrAccess, rdAck, rdAlt;
   logic [10:0] tfAddr, rdAddr;
   chp_pkg::chp_mode_t cardMode;
   chp_pkg::chp_xfer_t memXfer;
   int n_fail = 0, checks_done = 0, cycles = 0;

   // Pins resolve from every driver; host lanes carry hostData when the card lets go
   assign dataPinIn = {dataPinOe[1] ? dataPinOut[15:8] : hostData[15:8],
      dataPinOe[0] ? dataPinOut[7:0] : hostData[7:0]};
   assign diagPinIn = diagPinOe ? diagPinOut : 1'b1;
   assign activityPinIn = activityPinOe ? activityPinOut : actHost;

   card_host_pin_interface i_card_host_pin_interface (.sys_clk, .sys_rst, .addrPin,
      .low_byte_select_n, .high_byte_select_n, .io_read_strobe_n, .ide_mode_select_n,
      .drive_select_n, .attribute_select_n, .dataPinIn, .dataPinOut, .dataPinOe, .diagPinIn,
      .diagPinOut, .diagPinOe, .activityPinIn, .activityPinOut, .activityPinOe,
      .card_detect_one_n, .card_detect_two_n, .input_ack_n, .cfgIoMode, .interfaceReady,
      .cfgStatusChanged, .diagDone, .diagPassed, .driveActive, .tfReadData, .tfReadReq, .tfAddr,
      .tfAltBank, .hostWriteData, .cardMode, .modeValid, .deviceIsSlave, .slavePresent,
      .slaveDiagPassed, .memSelected, .memXfer, .memAttrAccess);
   chp_tf_model i_chp_tf_model (.sys_clk, .tfReadReq, .tfAddr, .tfReadData);

   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_fail++;
         stop_test();
      end
   end

   task stop_test;
      if (n_fail == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task start(input logic ide, input logic drv, input logic io);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      ide_mode_select_n <= ide;
      drive_select_n <= drv;
      cfgIoMode <= io;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      #1;
   endtask : start

   task wait_pins(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_pins

   function automatic logic [15:0] pins4();
      return {12'h000, diagPinOut, diagPinOe, activityPinOut, activityPinOe};
   endfunction : pins4

   // Bounded wait for the data lanes; a refused read simply times out with lanes off
   task do_read(input logic lo, input logic hi, input logic [10:0] a);
      int k;
      @(posedge sys_clk);
      addrPin <= a;
      low_byte_select_n <= lo;
      high_byte_select_n <= hi;
      io_read_strobe_n <= 1'b0;
      k = 0;
      while (dataPinOe === 2'b00 && k < 12)
      begin
         wait_pins(1);
         k++;
      end
      rdData = dataPinOut;
      rdOe = dataPinOe;
      rdAck = input_ack_n;
      rdAddr = tfAddr;
      rdAlt = tfAltBank;
      @(posedge sys_clk);
      io_read_strobe_n <= 1'b1;
      low_byte_select_n <= 1'b1;
      high_byte_select_n <= 1'b1;
      wait_pins(5);
      chk("bus off", 16'h0001, {13'h0000, dataPinOe, input_ack_n});
   endtask : do_read

   task test_mem;
      start(1'b1, 1'b0, 1'b0);
      chk("mode", 16'h0001, {13'h0000, cardMode});
      chk("detect", 16'h0000, {14'h0000, card_detect_one_n, card_detect_two_n});
      chk("battery", 16'h000F, pins4());
      chk("write lanes", 16'h5AC3, hostWriteData);
      do_read(1'b0, 1'b0, 11'h001);
      chk("mem read", 16'h0001, {13'h0000, rdOe, rdAck});
      for (int i = 0; i < 8; i++)
      begin
         @(posedge sys_clk);
         low_byte_select_n <= i[2];
         high_byte_select_n <= i[1];
         addrPin <= {10'h000, i[0]};
         attribute_select_n <= i[0];
         wait_pins(5);
         chk("xfer", (!i[2] && !i[1]) ? 16'h0001 : !i[2] ? (i[0] ? 16'h0003 : 16'h0002)
            : !i[1] ? 16'h0004 : 16'h0000, {13'h0000, memXfer});
         if (!(i[2] && i[1]))
            chk("attr", {14'h0001, !i[0]}, {14'h0000, memSelected, memAttrAccess});
      end
      low_byte_select_n <= 1'b1;
      high_byte_select_n <= 1'b1;
   endtask : test_mem

   task test_io;
      start(1'b1, 1'b0, 1'b1);
      do_read(1'b0, 1'b0, 11'h2B4);
      chk("unready", 16'h0001, {13'h0000, rdOe, rdAck});
      interfaceReady <= 1'b1;
      do_read(1'b0, 1'b0, 11'h5A5);
      chk("word data", 16'hB4B6, rdData);
      chk("word lanes", 16'h0006, {13'h0000, rdOe, rdAck});
      chk("io addr", 16'h05A5, {5'h00, rdAddr});
      do_read(1'b0, 1'b1, 11'h4C3);
      chk("odd data", 16'h0098, {8'h00, rdData[7:0]});
      chk("odd lanes", 16'h0002, {13'h0000, rdOe, rdAck});
      do_read(1'b1, 1'b0, 11'h4C2);
      chk("high data", 16'h9800, {rdData[15:8], 8'h00});
      chk("high lanes", 16'h0004, {13'h0000, rdOe, rdAck});
      cfgStatusChanged <= 1'b1;
      wait_pins(3);
      chk("status pin", 16'h0007, pins4());
      cfgStatusChanged <= 1'b0;
      wait_pins(3);
      chk("status idle", 16'h000F, pins4());
   endtask : test_io

   task test_ide_master;
      start(1'b0, 1'b0, 1'b0);
      chk("ide master", 16'h0008, {12'h000, cardMode, deviceIsSlave});
      interfaceReady <= 1'b0;
      do_read(1'b1, 1'b0, 11'h7F6);
      chk("ide unready", 16'h0001, {13'h0000, rdOe, rdAck});
      interfaceReady <= 1'b1;
      do_read(1'b1, 1'b0, 11'h7F6);
      chk("alt bank", 16'h000F, {12'h000, rdAlt, rdOe, rdAck});
      chk("ide addr", 16'h0006, {5'h00, rdAddr});
      chk("ide data", 16'h00D6, rdData);
      do_read(1'b0, 1'b1, 11'h7F1);
      chk("task bank", 16'h0007, {12'h000, rdAlt, rdOe, rdAck});
      ide_mode_select_n <= 1'b1;
      driveActive <= 1'b1;
      wait_pins(5);
      chk("mode held", 16'h0004, {13'h0000, cardMode});
      chk("activity", 16'h0001, pins4());
      driveActive <= 1'b0;
      actHost <= 1'b0;
      wait_pins(5);
      chk("slave seen", 16'h0002, {14'h0000, slavePresent, slaveDiagPassed});
      actHost <= 1'b1;
   endtask : test_ide_master

   task test_ide_slave;
      start(1'b0, 1'b1, 1'b0);
      chk("ide slave", 16'h0009, {12'h000, cardMode, deviceIsSlave});
      chk("slave present", 16'h0001, pins4());
      diagDone <= 1'b1;
      diagPassed <= 1'b1;
      wait_pins(3);
      chk("diag pass", 16'h0004, pins4());
   endtask : test_ide_slave

   initial
   begin
      test_mem();
      test_io();
      test_ide_master();
      test_ide_slave();
      stop_test();
   end
endmodule : card_host_pin_interface_tb
